// ==== pkg/sbl_pkg.sv ====
// Constants for the serial bootstrap loader sequencer.
// Assumes a single 10 MHz system clock and a synchronous active-high reset.
`default_nettype none
package sbl_pkg;
  // Clock
  localparam int          CLK_HZ          = 10_000_000;
  // Loaded block: 32 bytes into RAM words 0xFA40..0xFA5F
  localparam int          LOAD_COUNT      = 32;
  localparam logic [23:0] LOAD_FIRST_ADDR = 24'h00FA40;
  localparam logic [23:0] LOAD_LAST_ADDR  = 24'h00FA5F;
  // Flash window, segment 0 and its segment 1 copy
  localparam logic [23:0] FLASH_S0_LO     = 24'h000000;
  localparam logic [23:0] FLASH_S0_HI     = 24'h007FFF;
  localparam logic [23:0] FLASH_S1_LO     = 24'h010000;
  localparam logic [23:0] FLASH_S1_HI     = 24'h017FFF;
  localparam logic [23:0] RESET_VECTOR    = 24'h000000;
  // Rate reload derivation
  localparam logic [15:0] RELOAD_OFFSET   = 16'h0024;  // 36
  localparam logic [15:0] RELOAD_DIVISOR  = 16'h0048;  // 72
  localparam int          BIT_SAMPLES     = 16;        // Receiver oversampling
  localparam logic [4:0]  BAUD_PRESCALE   = 5'h01;     // 32 = 2 x 16 samples
  // Measurement timer: one count per four clocks, so the nine low bit
  // times of the zero byte give 9/4 of the clocks per host bit
  localparam logic [3:0]  MEAS_STEP       = 4'h1;
  localparam logic [3:0]  MEAS_DIV        = 4'h4;
  // Identification byte: arbitrary neutral value
  localparam logic [7:0]  ID_BYTE_DEF     = 8'hA5;
  // FIFO
  localparam int          FIFO_DEPTH      = 16;
  localparam int          FIFO_WIDTH      = 8;
  typedef enum logic [2:0] {
    SBL_IDLE, SBL_MEASURE, SBL_CALC, SBL_SEND_ID, SBL_LOAD, SBL_JUMP,
    SBL_RUN, SBL_FAULT
  } sbl_state_e;
endpackage : sbl_pkg
`default_nettype wire

// ==== rtl/sbl_fifo.sv ====
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module sbl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             srst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    rd_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  // Handshake decode
  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[rd_r];

  // Storage writes
  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem_r[wr_r] <= in_data;
  end

  // Pointers and fill level
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wr_r <= wr_r + 1'b1;
      if (pop)
        rd_r <= rd_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sbl_fifo
`default_nettype wire

// ==== rtl/sbl_uart.sv ====
// Asynchronous serial channel: 16x oversampled receiver and transmitter.
// Assumes a synchronised receive line and a one-cycle sample tick.
`timescale 1ns/10ps
`default_nettype none
module sbl_uart
  import sbl_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       srst,
  // Rate
  input  wire logic       tick,
  // Serial lines
  input  wire logic       rx_sync,
  output logic            tx_line,
  // Received bytes
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  input  wire logic       rx_enable,
  // Bytes to send
  input  wire logic       tx_start,
  input  wire logic [7:0] tx_data,
  output logic            tx_busy
);
  logic [3:0] rph_r;
  logic [3:0] rbit_r;
  logic [7:0] rsh_r;
  logic       ract_r;
  logic [3:0] tph_r;
  logic [3:0] tbit_r;
  logic [9:0] tsh_r;
  logic       mid;

  assign mid     = tick && (rph_r == 4'h7);
  assign tx_line = tsh_r[0];
  assign tx_busy = (tbit_r != 4'h0);

  // Receiver: start detect, mid-bit sampling
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      ract_r   <= 1'b0;
      rph_r    <= 4'h0;
      rbit_r   <= 4'h0;
      rsh_r    <= 8'h00;
      rx_valid <= 1'b0;
      rx_data  <= 8'h00;
    end
    else
    begin
      rx_valid <= 1'b0;
      if (!ract_r)
      begin
        rph_r  <= 4'h0;
        rbit_r <= 4'h0;
        if (rx_enable && !rx_sync)
          ract_r <= 1'b1;
      end
      else if (tick)
      begin
        rph_r <= rph_r + 4'h1;
        if (mid)
        begin
          rbit_r <= rbit_r + 4'h1;
          if (rbit_r == 4'h0 && rx_sync)
            ract_r <= 1'b0;              // False start
          else if (rbit_r == 4'h9)
          begin
            ract_r   <= 1'b0;
            rx_valid <= rx_sync;         // Framing error drops byte
            rx_data  <= rsh_r;
          end
          else if (rbit_r != 4'h0)
            rsh_r <= {rx_sync, rsh_r[7:1]};
        end
      end
    end
  end

  // Transmitter: LSB first, one start, one stop bit
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      tsh_r  <= 10'h3FF;
      tbit_r <= 4'h0;
      tph_r  <= 4'h0;
    end
    else if (tbit_r == 4'h0)
    begin
      tph_r <= 4'h0;
      if (tx_start)
      begin
        tsh_r  <= {1'b1, tx_data, 1'b0};
        tbit_r <= 4'hA;
      end
    end
    else if (tick)
    begin
      tph_r <= tph_r + 4'h1;
      if (tph_r == 4'hF)
      begin
        tsh_r  <= {1'b1, tsh_r[9:1]};
        tbit_r <= tbit_r - 4'h1;
      end
    end
  end
endmodule : sbl_uart
`default_nettype wire

// ==== rtl/sbl_loader.sv ====
// Serial bootstrap loader sequencer: measures the zero byte, derives
// the serial rate, returns the identification byte, loads 32 bytes into
// RAM and hands the start address to the core.
// Assumes the core executes from loader_jump_addr on loader_jump and
// that the RAM takes one write per ram_we pulse.
`timescale 1ns/10ps
`default_nettype none
module sbl_loader
  import sbl_pkg::*;
#(
  parameter logic [7:0] ID_BYTE = ID_BYTE_DEF  // Arbitrary value
) (
  // Clock and resets
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        hw_reset,
  input  wire logic        sw_reset,
  // Straps
  input  wire logic        boot_select_strap,
  input  wire logic        external_access_select,
  // Serial pins
  input  wire logic        boot_receive_line,
  output logic             boot_transmit_line,
  output logic             boot_transmit_oe,
  // RAM write port
  output logic             ram_we,
  output logic [23:0]      ram_addr,
  output logic [7:0]       ram_wdata,
  // Core hand-off
  output logic             loader_jump,
  output logic [23:0]      loader_jump_addr,
  output logic             start_external,
  // Fetch redirection
  input  wire logic [23:0] fetch_addr,
  output logic             fetch_to_boot_rom,
  output logic             data_read_undefined,
  // Mode and status
  output logic             boot_loader_mode,
  output logic             watchdog_disable,
  output logic             loader_fault,
  output logic [15:0]      serial_rate_reload,
  output logic             loader_busy
);
  sbl_state_e  state_r;
  sbl_state_e  state_nxt;
  logic        rx_m_r;
  logic        rx_s_r;
  logic        rx_d_r;
  logic        strap_m_r;
  logic        strap_s_r;
  logic        eas_m_r;
  logic        eas_s_r;
  logic        mode_r;
  logic        hw_d_r;
  logic [15:0] bit_length_timer;
  logic [3:0]  frac_r;
  logic        ovf_r;
  logic [15:0] div_r;
  logic [15:0] quot_r;
  logic [4:0]  pre_r;
  logic [15:0] bcnt_r;
  logic        tick;
  logic [5:0]  cnt_r;
  logic        id_sent_r;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        tx_busy;
  logic        f_valid;
  logic        f_ready;
  logic [7:0]  f_data;
  logic        f_in_ready;
  logic        rx_fall;
  logic        rx_rise;
  logic [4:0]  frac_sum;
  logic        in_s0;
  logic        in_s1;
  logic        flash_hit;
  logic        store;

  // Pin synchronisers, then receive edge delay
  always_ff @(posedge clk_sys)
  begin
    rx_m_r    <= boot_receive_line;
    rx_s_r    <= rx_m_r;
    rx_d_r    <= rx_s_r;
    strap_m_r <= boot_select_strap;
    strap_s_r <= strap_m_r;
    eas_m_r   <= external_access_select;
    eas_s_r   <= eas_m_r;
  end
  assign rx_fall = rx_d_r && !rx_s_r;
  assign rx_rise = !rx_d_r && rx_s_r;

  // Mode flag: strap caught on hardware reset release
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      mode_r <= 1'b0;
      hw_d_r <= 1'b0;
    end
    else
    begin
      hw_d_r <= hw_reset;
      if (sw_reset)
        mode_r <= 1'b0;
      else if (hw_d_r && !hw_reset)
        mode_r <= !strap_s_r;
    end
  end
  assign boot_loader_mode = mode_r;
  assign watchdog_disable = mode_r;

  // Flash window decode for fetch redirection
  assign in_s0 = fetch_addr >= FLASH_S0_LO && fetch_addr <= FLASH_S0_HI;
  assign in_s1 = fetch_addr >= FLASH_S1_LO && fetch_addr <= FLASH_S1_HI;
  assign flash_hit           = in_s0 || in_s1;
  assign fetch_to_boot_rom   = mode_r && flash_hit;
  assign data_read_undefined = mode_r && flash_hit;

  // Sequencer next state
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      SBL_IDLE:    if (mode_r && rx_fall) state_nxt = SBL_MEASURE;
      SBL_MEASURE:
        if (ovf_r)
          state_nxt = SBL_FAULT;
        else if (rx_rise)
          state_nxt = SBL_CALC;
      SBL_CALC:
        if (bit_length_timer < RELOAD_OFFSET)
          state_nxt = SBL_FAULT;
        else if (div_r < RELOAD_DIVISOR)
          state_nxt = SBL_SEND_ID;
      SBL_SEND_ID: if (id_sent_r && !tx_busy) state_nxt = SBL_LOAD;
      SBL_LOAD:    if (cnt_r == 6'(LOAD_COUNT)) state_nxt = SBL_JUMP;
      SBL_JUMP:    state_nxt = SBL_RUN;
      SBL_RUN:     state_nxt = SBL_RUN;
      SBL_FAULT:   state_nxt = SBL_FAULT;
    endcase
  end

  // Zero byte measurement, one count per four clocks
  assign frac_sum = {1'b0, frac_r} + {1'b0, MEAS_STEP};
  always_ff @(posedge clk_sys)
  begin
    if (srst || state_r == SBL_IDLE)
    begin
      bit_length_timer <= 16'h0000;
      frac_r           <= 4'h0;
      ovf_r            <= 1'b0;
    end
    else if (state_r == SBL_MEASURE)
    begin
      // Remainder below four stays, each full four adds one count
      frac_r <= {2'b00, frac_sum[1:0]};
      {ovf_r, bit_length_timer} <=
        {ovf_r, bit_length_timer} + {15'h0000, frac_sum[3:2]};
    end
  end

  // Reload: (count - 36) / 72 by repeated subtraction
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      div_r  <= 16'h0000;
      quot_r <= 16'h0000;
    end
    else if (state_r == SBL_MEASURE)
    begin
      div_r  <= bit_length_timer - RELOAD_OFFSET;
      quot_r <= 16'h0000;
    end
    else if (state_r == SBL_CALC && div_r >= RELOAD_DIVISOR)
    begin
      div_r  <= div_r - RELOAD_DIVISOR;
      quot_r <= quot_r + 16'h0001;
    end
  end
  assign serial_rate_reload = quot_r;

  // Baud divider: tick every 2*(reload+1) clocks, 16 ticks per bit
  always_ff @(posedge clk_sys)
  begin
    if (srst || state_r == SBL_CALC)
    begin
      pre_r  <= 5'h00;
      bcnt_r <= 16'h0000;
    end
    else if (bcnt_r == quot_r)
    begin
      bcnt_r <= 16'h0000;
      pre_r  <= (pre_r == BAUD_PRESCALE) ? 5'h00 : pre_r + 5'h01;
    end
    else
      bcnt_r <= bcnt_r + 16'h0001;
  end
  assign tick = (bcnt_r == quot_r) && (pre_r == BAUD_PRESCALE);

  // Identification send and byte count
  assign store = f_valid && f_ready;
  // Cleared in idle so a later loader entry starts a fresh sequence
  always_ff @(posedge clk_sys)
  begin
    if (srst || state_r == SBL_IDLE)
    begin
      id_sent_r <= 1'b0;
      cnt_r     <= 6'h00;
    end
    else
    begin
      if (state_r == SBL_SEND_ID)
        id_sent_r <= 1'b1;
      if (store)
        cnt_r <= cnt_r + 6'h01;
    end
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (srst || hw_reset || sw_reset)
      state_r <= SBL_IDLE;
    else
      state_r <= state_nxt;
  end

  // Transmit pin driven once the channel is set up
  assign boot_transmit_oe = mode_r && (state_r == SBL_SEND_ID ||
    state_r == SBL_LOAD || state_r == SBL_JUMP || state_r == SBL_RUN);
  assign loader_busy    = state_r != SBL_IDLE && state_r != SBL_RUN &&
                          state_r != SBL_FAULT;
  assign loader_fault   = state_r == SBL_FAULT;
  assign start_external = !mode_r && !eas_s_r;
  assign f_ready        = state_r == SBL_LOAD && cnt_r < 6'(LOAD_COUNT);

  // RAM write and jump outputs
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      ram_we           <= 1'b0;
      ram_addr         <= LOAD_FIRST_ADDR;
      ram_wdata        <= 8'h00;
      loader_jump      <= 1'b0;
      loader_jump_addr <= RESET_VECTOR;
    end
    else
    begin
      ram_we      <= store;
      loader_jump <= state_r == SBL_JUMP;
      if (store)
      begin
        ram_addr  <= LOAD_FIRST_ADDR + 24'(cnt_r);
        ram_wdata <= f_data;
      end
      if (state_r == SBL_JUMP)
        loader_jump_addr <= LOAD_FIRST_ADDR;
      else if (!mode_r)
        loader_jump_addr <= RESET_VECTOR;
    end
  end

  // Serial channel
  sbl_uart u_uart (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .tick      (tick),
    .rx_sync   (rx_s_r),
    .tx_line   (boot_transmit_line),
    .rx_valid  (rx_valid),
    .rx_data   (rx_data),
    .rx_enable (state_r == SBL_LOAD),
    .tx_start  (state_r == SBL_SEND_ID && !id_sent_r),
    .tx_data   (ID_BYTE),
    .tx_busy   (tx_busy)
  );

  // Receive buffer between channel and RAM writer
  sbl_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .in_valid  (rx_valid),
    .in_ready  (f_in_ready),
    .in_data   (rx_data),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  // Checks
  mode_wd_a: assert property (@(posedge clk_sys) disable iff (srst)
    $rose(watchdog_disable) |-> $past(hw_reset, 2))
    else $error("watchdog disabled outside hardware reset release");
  swrst_end_a: assert property (@(posedge clk_sys) disable iff (srst)
    sw_reset |=> !boot_loader_mode)
    else $error("software reset kept mode");
  redirect_a: assert property (@(posedge clk_sys) disable iff (srst)
    (boot_loader_mode && fetch_addr <= FLASH_S1_HI &&
     fetch_addr >= FLASH_S1_LO) |-> fetch_to_boot_rom)
    else $error("segment one fetch not redirected");
  ovf_stop_a: assert property (@(posedge clk_sys) disable iff (srst)
    ovf_r && state_r == SBL_MEASURE && !hw_reset && !sw_reset
    |=> state_r == SBL_FAULT)
    else $error("overflow not trapped");
  jump_addr_a: assert property (@(posedge clk_sys) disable iff (srst)
    state_r == SBL_JUMP |=> loader_jump && loader_jump_addr == LOAD_FIRST_ADDR)
    else $error("bad jump");
  load_cnt_a: assert property (@(posedge clk_sys) disable iff (srst)
    cnt_r <= 6'(LOAD_COUNT))
    else $error("too many bytes stored");
  ram_range_a: assert property (@(posedge clk_sys) disable iff (srst)
    ram_we |-> ram_addr >= LOAD_FIRST_ADDR && ram_addr <= LOAD_LAST_ADDR)
    else $error("store outside load area");
  run_stay_a: assert property (@(posedge clk_sys) disable iff (srst)
    state_r == SBL_RUN && !hw_reset && !sw_reset |=> state_r == SBL_RUN)
    else $error("left run state");
  fifo_room_a: assert property (@(posedge clk_sys) disable iff (srst)
    rx_valid |-> f_in_ready)
    else $error("receive buffer overrun");
  jump_c: cover property (@(posedge clk_sys) loader_jump);
  load_c: cover property (@(posedge clk_sys) ram_we);
  fault_c: cover property (@(posedge clk_sys) loader_fault);
  id_c: cover property (@(posedge clk_sys) state_r == SBL_SEND_ID);
endmodule : sbl_loader
`default_nettype wire

// ==== testbench/sbl_host.sv ====
// Host model: sends boot bytes on the receive line, reads the reply.
// Assumes 8N1 framing, LSB first, both lines idle high.
`timescale 1ns/10ps
`default_nettype none
module sbl_host (
  // Clock
  input  wire logic clk_sys,
  // Serial lines
  output logic      rx_line,
  input  wire logic tx_line
);
  // Line idles high between frames
  initial rx_line = 1'b1;

  // One 8N1 frame, bit_clks clocks per bit
  task automatic send_byte(input logic [7:0] b, input int bit_clks);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(negedge clk_sys);
      rx_line = frame[i];
      repeat (bit_clks - 1) @(negedge clk_sys);
    end
  endtask : send_byte

  // Hold the line low for a given number of clocks, then release it
  task automatic hold_low(input int clks);
    @(negedge clk_sys);
    rx_line = 1'b0;
    repeat (clks) @(negedge clk_sys);
    rx_line = 1'b1;
  endtask : hold_low

  // Wait for a start bit, then sample each bit in its middle, on the
  // falling edge so that the line has settled after its launching edge
  task automatic get_byte(output logic [7:0] b, output logic ok,
                          input int bit_clks);
    int wait_cnt;
    wait_cnt = 0;
    ok = 1'b0;
    b = 8'h00;
    while (tx_line !== 1'b0 && wait_cnt < 3000)
    begin
      @(negedge clk_sys);
      wait_cnt++;
    end
    if (wait_cnt < 3000)
    begin
      repeat (bit_clks / 2) @(negedge clk_sys);
      ok = (tx_line === 1'b0);
      for (int i = 0; i < 8; i++)
      begin
        repeat (bit_clks) @(negedge clk_sys);
        b[i] = tx_line;
      end
      repeat (bit_clks) @(negedge clk_sys);
      ok = ok && (tx_line === 1'b1);  // Stop bit high
    end
  endtask : get_byte
endmodule : sbl_host
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the bootstrap loader sequencer.
// Assumes the host model drives the receive line; 10 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import sbl_pkg::*;
  localparam int          BIT_CLKS   = 64;
  localparam logic [15:0] EXP_RELOAD = 16'h0001;
  localparam int          TIME_LIMIT = 60000;

  logic        clk_sys, srst, hw_reset, sw_reset, strap, ext_sel;
  logic        rx_line, tx_line, tx_oe, ram_we, jump, start_ext;
  logic        to_rom, rd_undef, mode, wdog_off, fault, busy, ok;
  logic        host_tx;
  logic [23:0] ram_addr, jump_addr, fetch_addr, jump_seen;
  logic [7:0]  ram_wdata, rx_byte;
  logic [15:0] reload;
  logic [23:0] wr_addr[$];
  logic [7:0]  wr_data[$];
  int          miscompares, num_checks, cycles, n_jumps, writes_at_jump;

  sbl_loader sbl_loader_i (
    .clk_sys(clk_sys), .srst(srst), .hw_reset(hw_reset),
    .sw_reset(sw_reset), .boot_select_strap(strap),
    .external_access_select(ext_sel), .boot_receive_line(rx_line),
    .boot_transmit_line(tx_line), .boot_transmit_oe(tx_oe),
    .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .loader_jump(jump), .loader_jump_addr(jump_addr),
    .start_external(start_ext), .fetch_addr(fetch_addr),
    .fetch_to_boot_rom(to_rom), .data_read_undefined(rd_undef),
    .boot_loader_mode(mode), .watchdog_disable(wdog_off),
    .loader_fault(fault), .serial_rate_reload(reload), .loader_busy(busy)
  );
  // Host sees the pin pulled high while the loader does not drive it
  assign host_tx = tx_oe ? tx_line : 1'b1;
  sbl_host sbl_host_i (.clk_sys(clk_sys), .rx_line(rx_line),
                       .tx_line(host_tx));

  // Clock, 100 ns period
  initial clk_sys = 1'b0;
  always #50 clk_sys = ~clk_sys;

  // Record RAM writes and jumps, cut a hang short
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (ram_we === 1'b1)
    begin
      wr_addr.push_back(ram_addr);
      wr_data.push_back(ram_wdata);
    end
    if (jump === 1'b1)
    begin
      n_jumps <= n_jumps + 1;
      writes_at_jump <= wr_addr.size();
      jump_seen <= jump_addr;
    end
    if (cycles >= TIME_LIMIT)
    begin
      miscompares++;
      final_report();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Hardware reset pulse with the given strap level
  task automatic hw_pulse(input logic lvl);
    @(negedge clk_sys);
    strap = lvl;
    hw_reset = 1'b1;
    repeat (2) @(negedge clk_sys);
    hw_reset = 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask : hw_pulse

  task automatic test_normal_reset();
    hw_pulse(1'b1);
    check(mode, 1'b0);
    check(wdog_off, 1'b0);
    ext_sel = 1'b0;
    repeat (3) @(negedge clk_sys);
    check(start_ext, 1'b1);
    ext_sel = 1'b1;
    repeat (3) @(negedge clk_sys);
    check(start_ext, 1'b0);
    check(to_rom, 1'b0);
    $display("test normal_reset done");
  endtask : test_normal_reset

  task automatic test_enter();
    logic [23:0] addrs[7];
    logic        exp[7];
    addrs = '{24'h000000, 24'h007FFF, 24'h008000, 24'h010000,
              24'h017FFF, 24'h018000, 24'h00FA40};
    exp = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    hw_pulse(1'b0);
    check(mode, 1'b1);
    check(wdog_off, 1'b1);
    check(busy, 1'b0);
    for (int i = 0; i < 7; i++)
    begin
      @(negedge clk_sys);
      fetch_addr = addrs[i];
      #10;
      check(to_rom, exp[i]);
      check(rd_undef, exp[i]);
    end
    $display("test enter done");
  endtask : test_enter

  task automatic test_load();
    fork
      sbl_host_i.send_byte(8'h00, BIT_CLKS);
      sbl_host_i.get_byte(rx_byte, ok, BIT_CLKS);
    join
    check(ok, 1'b1);
    check(rx_byte, ID_BYTE_DEF);
    check(tx_oe, 1'b1);
    check(busy, 1'b1);
    check(reload, EXP_RELOAD);
    // Let the identification byte finish before the first load byte
    repeat (BIT_CLKS) @(negedge clk_sys);
    for (int n = 0; n < 32; n++)
      sbl_host_i.send_byte(8'h5A ^ 8'(n * 7), BIT_CLKS);
    repeat (20) @(negedge clk_sys);
    check(wr_addr.size(), 32);
    for (int n = 0; n < wr_addr.size(); n++)
    begin
      check(wr_addr[n], 24'h00FA40 + 24'(n));
      check(wr_data[n], 8'h5A ^ 8'(n * 7));
    end
    check(n_jumps, 1);
    check(writes_at_jump, 32);
    check(jump_seen, 24'h00FA40);
    sbl_host_i.send_byte(8'hC3, BIT_CLKS);
    repeat (20) @(negedge clk_sys);
    check(wr_addr.size(), 32);
    check(busy, 1'b0);
    check(mode, 1'b1);
    check(wdog_off, 1'b1);
    $display("test load done");
  endtask : test_load

  task automatic test_bad_count();
    int lows;
    lows = 0;
    hw_pulse(1'b0);
    sbl_host_i.hold_low(9);
    repeat (600) @(posedge clk_sys)
      if (tx_line !== 1'b1) lows++;
    check(fault, 1'b1);
    check(lows, 0);
    check(tx_oe, 1'b0);
    $display("test bad_count done");
  endtask : test_bad_count

  task automatic test_resets();
    @(negedge clk_sys);
    strap = 1'b0;
    sw_reset = 1'b1;
    repeat (2) @(negedge clk_sys);
    sw_reset = 1'b0;
    repeat (3) @(negedge clk_sys);
    check(mode, 1'b0);
    fetch_addr = 24'h000000;
    #10;
    check(to_rom, 1'b0);
    hw_pulse(1'b0);
    check(mode, 1'b1);
    hw_pulse(1'b1);
    check(mode, 1'b0);
    check(wdog_off, 1'b0);
    check(jump_addr, 24'h000000);
    $display("test resets done");
  endtask : test_resets

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  // Main sequence
  initial
  begin
    srst = 1'b1;
    hw_reset = 1'b0;
    sw_reset = 1'b0;
    strap = 1'b1;
    ext_sel = 1'b0;
    fetch_addr = 24'h000000;
    miscompares = 0;
    num_checks = 0;
    cycles = 0;
    n_jumps = 0;
    writes_at_jump = 0;
    jump_seen = 24'h000000;
    repeat (3) @(negedge clk_sys);
    srst = 1'b0;
    test_normal_reset();
    test_enter();
    test_load();
    test_bad_count();
    test_resets();
    final_report();
  end
endmodule : tb_top
`default_nettype wire
